// *** rtl/nv_access_pkg.sv ***
// Purpose: shared constants and types for the data nonvolatile byte access block
// Assumes: 250 MHz core clock, byte-addressed Avalon-MM register window
// Notes: one word per register, data in bits 7:0
package nv_access_pkg;
  localparam int CLK_MHZ = 250;
  localparam int PWRT_MS = 72;
  localparam int PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
  localparam int WRITE_CYCLES = 1000;
  localparam int NV_BYTES = 1024;
  localparam int NV_AW = 10;
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;

  localparam logic [BUS_AW-1:0] OFS_ADDR_LOWER = 5'h00;
  localparam logic [BUS_AW-1:0] OFS_ADDR_UPPER = 5'h04;
  localparam logic [BUS_AW-1:0] OFS_DATA = 5'h08;
  localparam logic [BUS_AW-1:0] OFS_CTRL = 5'h0C;
  localparam logic [BUS_AW-1:0] OFS_KEY = 5'h10;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 5'h14;

  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_PERMIT = 2;
  localparam int CTRL_ABORT = 3;
  localparam int CTRL_CFG = 6;
  localparam int CTRL_PGM = 7;
  localparam int STATUS_DONE = 0;
  localparam int UPPER_BITS = NV_AW - 8;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [NV_AW-1:0] addr;
    logic [7:0] wdata;
  } ext_req_t;

  typedef struct packed {
    logic ack;
    logic denied;
    logic [7:0] rdata;
  } ext_rsp_t;
endpackage

// *** rtl/nv_unlock_seq.sv ***
// Purpose: tracks the two-key unlock sequence that must precede a write start
// Assumes: one accepted bus write per pulse
// Notes: any unrelated write or a consume drops the sequence
`timescale 1ns/10ps
module nv_unlock_seq (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic keyWr,
  input wire logic [7:0] keyData,
  input wire logic clear,
  output logic armed
);
  nv_access_pkg::key_state_t state_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= nv_access_pkg::KEY_IDLE;
    end else if (clear) begin
      state_r <= nv_access_pkg::KEY_IDLE;
    end else if (keyWr) begin
      unique case (state_r)
        nv_access_pkg::KEY_HALF: begin
          state_r <= (keyData == nv_access_pkg::KEY_SECOND) ? nv_access_pkg::KEY_ARMED : nv_access_pkg::KEY_IDLE;
        end
        nv_access_pkg::KEY_IDLE, nv_access_pkg::KEY_ARMED: begin
          state_r <= (keyData == nv_access_pkg::KEY_FIRST) ? nv_access_pkg::KEY_HALF : nv_access_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  assign armed = (state_r == nv_access_pkg::KEY_ARMED);

  arm_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(armed) |-> $past(keyWr) && $past(keyData) == nv_access_pkg::KEY_SECOND)
    else $error("unlock armed without second key");
endmodule

// *** rtl/nv_write_timer.sv ***
// Purpose: self-timed erase and program interval for one byte
// Assumes: start only while idle
// Notes: done is a one-cycle pulse in the last busy cycle
`timescale 1ns/10ps
module nv_write_timer #(
  parameter int CYCLES = nv_access_pkg::WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_r;
  logic busy_r;
  logic [CW-1:0] runLen_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (abort) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= '0;
    end else if (busy_r) begin
      busy_r <= (cnt_r != LAST);
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign busy = busy_r;
  assign done = busy_r && (cnt_r == LAST) && !abort;

  // Independent run length so a bad count reload shows up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      runLen_r <= '0;
    end else if (!busy_r) begin
      runLen_r <= '0;
    end else begin
      runLen_r <= runLen_r + CW'(1);
    end
  end

  write_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |-> runLen_r == LAST)
    else $error("write ended at wrong count");
endmodule

// *** rtl/nv_access_ctrl.sv ***
// Purpose: register window, read path, write start guard and array for data nonvolatile storage
// Assumes: Avalon-MM slave with one wait state; soft reset events arrive as clock pulses
// Notes: array contents survive every reset
`timescale 1ns/10ps
module nv_access_ctrl #(
  parameter int PWRT_CYCLES = nv_access_pkg::PWRT_CYCLES,
  parameter int WRITE_CYCLES = nv_access_pkg::WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [nv_access_pkg::BUS_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [nv_access_pkg::BUS_DW-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [nv_access_pkg::BUS_DW-1:0] readdata,
  output logic waitrequest,
  input wire logic masterClearReset,
  input wire logic watchdogReset,
  input wire logic codeProtect,
  input wire nv_access_pkg::ext_req_t extReq,
  output nv_access_pkg::ext_rsp_t extRsp,
  output logic writeDoneFlag,
  output logic writeBusy
);
  localparam int PW = $clog2(PWRT_CYCLES + 1);
  localparam logic [PW-1:0] PWRT_LAST = PW'(PWRT_CYCLES - 1);
  localparam int UB = nv_access_pkg::UPPER_BITS;

  function automatic logic hit(input logic [nv_access_pkg::BUS_AW-1:0] a,
                               input logic [nv_access_pkg::BUS_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0] mem [nv_access_pkg::NV_BYTES];
  logic busAck_r;
  logic [nv_access_pkg::BUS_DW-1:0] readdata_r;
  logic [7:0] addrLower_r;
  logic [UB-1:0] addrUpper_r;
  logic [7:0] dataBuf_r;
  logic pgmSel_r;
  logic cfgSel_r;
  logic writePermit_r;
  logic abortFlag_r;
  logic doneFlag_r;
  logic [PW-1:0] pwrtCnt_r;
  logic pwrtDone_r;
  nv_access_pkg::ext_rsp_t extRsp_r;

  logic wrAccept;
  logic wrLane;
  logic softRst;
  logic busy;
  logic timerDone;
  logic abortEvt;
  logic keyArmed;
  logic wrCtrl;
  logic rdGo;
  logic startWr;
  logic doneClear;
  logic extOk;
  logic [nv_access_pkg::NV_AW-1:0] nvAddr;
  logic [7:0] memRd;
  logic [7:0] ctrlView;
  logic [nv_access_pkg::BUS_DW-1:0] readNxt;

  assign softRst = masterClearReset || watchdogReset;
  assign abortEvt = softRst && busy;
  // One wait state so read data can come straight from a flop
  assign waitrequest = (read || write) && !busAck_r;
  assign wrLane = write && busAck_r && byteenable[0];
  assign wrAccept = wrLane && !busy;
  assign wrCtrl = wrAccept && hit(address, nv_access_pkg::OFS_CTRL);
  assign nvAddr = {addrUpper_r, addrLower_r};
  assign memRd = mem[nvAddr];

  // Select bits taken from the same write that raises the strobe
  assign rdGo = wrCtrl && writedata[nv_access_pkg::CTRL_RD] && !writedata[nv_access_pkg::CTRL_PGM]
                && !writedata[nv_access_pkg::CTRL_CFG];
  // Stored permit only: a write raising both bits starts nothing
  assign startWr = wrCtrl && writedata[nv_access_pkg::CTRL_WR] && writePermit_r && keyArmed
                   && pwrtDone_r && !softRst && !writedata[nv_access_pkg::CTRL_PGM]
                   && !writedata[nv_access_pkg::CTRL_CFG];
  assign doneClear = wrLane && hit(address, nv_access_pkg::OFS_STATUS)
                     && writedata[nv_access_pkg::STATUS_DONE];
  // Port shut while busy so the timed write owns the cell
  assign extOk = !codeProtect && !busy;

  nv_unlock_seq u_unlock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .keyWr(wrAccept && hit(address, nv_access_pkg::OFS_KEY)),
    .keyData(writedata[7:0]),
    .clear(softRst || (wrLane && !hit(address, nv_access_pkg::OFS_KEY))),
    .armed(keyArmed)
  );

  nv_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(startWr),
    .abort(abortEvt),
    .busy(busy),
    .done(timerDone)
  );

  // Bus handshake and read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busAck_r <= 1'b0;
      readdata_r <= '0;
    end else begin
      busAck_r <= (read || write) && !busAck_r;
      if (read && !busAck_r) begin
        readdata_r <= readNxt;
      end
    end
  end

  always_comb begin
    ctrlView = nv_access_pkg::BYTE_ZERO;
    ctrlView[nv_access_pkg::CTRL_PGM] = pgmSel_r;
    ctrlView[nv_access_pkg::CTRL_CFG] = cfgSel_r;
    ctrlView[nv_access_pkg::CTRL_ABORT] = abortFlag_r;
    ctrlView[nv_access_pkg::CTRL_PERMIT] = writePermit_r;
    ctrlView[nv_access_pkg::CTRL_WR] = busy;
    readNxt = '0;
    unique case (address)
      nv_access_pkg::OFS_ADDR_LOWER: readNxt[7:0] = addrLower_r;
      nv_access_pkg::OFS_ADDR_UPPER: readNxt[UB-1:0] = addrUpper_r;
      nv_access_pkg::OFS_DATA: readNxt[7:0] = dataBuf_r;
      nv_access_pkg::OFS_CTRL: readNxt[7:0] = ctrlView;
      nv_access_pkg::OFS_STATUS: readNxt[nv_access_pkg::STATUS_DONE] = doneFlag_r;
      default: readNxt = '0;
    endcase
  end

  // Address pair; soft resets zero it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrLower_r <= '0;
      addrUpper_r <= '0;
    end else if (softRst) begin
      addrLower_r <= '0;
      addrUpper_r <= '0;
    end else if (wrAccept && hit(address, nv_access_pkg::OFS_ADDR_LOWER)) begin
      addrLower_r <= writedata[7:0];
    end else if (wrAccept && hit(address, nv_access_pkg::OFS_ADDR_UPPER)) begin
      addrUpper_r <= writedata[UB-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBuf_r <= '0;
    end else if (softRst) begin
      dataBuf_r <= '0;
    end else if (rdGo) begin
      dataBuf_r <= memRd;
    end else if (wrAccept && hit(address, nv_access_pkg::OFS_DATA)) begin
      dataBuf_r <= writedata[7:0];
    end
  end

  // Control bits; select bits survive soft resets for tracing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgmSel_r <= 1'b0;
      cfgSel_r <= 1'b0;
      writePermit_r <= 1'b0;
    end else if (softRst) begin
      writePermit_r <= 1'b0;
    end else if (wrCtrl) begin
      pgmSel_r <= writedata[nv_access_pkg::CTRL_PGM];
      cfgSel_r <= writedata[nv_access_pkg::CTRL_CFG];
      writePermit_r <= writedata[nv_access_pkg::CTRL_PERMIT];
    end
  end

  // Abort flag: hardware set wins over software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      abortFlag_r <= 1'b0;
    end else if (abortEvt) begin
      abortFlag_r <= 1'b1;
    end else if (wrCtrl) begin
      abortFlag_r <= writedata[nv_access_pkg::CTRL_ABORT];
    end
  end

  // Done flag: write one to clear, completion wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag_r <= 1'b0;
    end else if (timerDone) begin
      doneFlag_r <= 1'b1;
    end else if (doneClear) begin
      doneFlag_r <= 1'b0;
    end
  end

  // Power-up timer; counts once after power-on only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrtCnt_r <= '0;
      pwrtDone_r <= 1'b0;
    end else if (!pwrtDone_r) begin
      pwrtCnt_r <= pwrtCnt_r + PW'(1);
      pwrtDone_r <= (pwrtCnt_r == PWRT_LAST);
    end
  end

  // Array: erase at start, program at end; an abort leaves it erased
  always_ff @(posedge core_clk) begin
    if (startWr) begin
      mem[nvAddr] <= nv_access_pkg::ERASED_BYTE;
    end else if (timerDone) begin
      mem[nvAddr] <= dataBuf_r;
    end else if (extReq.wr && extOk) begin
      mem[extReq.addr] <= extReq.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extRsp_r <= '0;
    end else begin
      extRsp_r.ack <= extReq.rd || extReq.wr;
      extRsp_r.denied <= (extReq.rd || extReq.wr) && !extOk;
      extRsp_r.rdata <= (extReq.rd && extOk) ? mem[extReq.addr] : nv_access_pkg::BYTE_ZERO;
    end
  end

  assign readdata = readdata_r;
  assign extRsp = extRsp_r;
  assign writeDoneFlag = doneFlag_r;
  assign writeBusy = busy;

  read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdGo |=> dataBuf_r == $past(memRd))
    else $error("read strobe did not load data buffer");

  data_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rdGo && !softRst && !(wrAccept && hit(address, nv_access_pkg::OFS_DATA)) |=> $stable(dataBuf_r))
    else $error("data buffer changed without cause");

  start_guard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(busy) |-> $past(writePermit_r) && $past(keyArmed) && $past(pwrtDone_r))
    else $error("write started without permit or keys");

  permit_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timerDone && !wrCtrl |=> writePermit_r == $past(writePermit_r))
    else $error("hardware changed write permit");

  write_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && !softRst |=> $stable(addrLower_r) && $stable(addrUpper_r) && $stable(dataBuf_r)
    && $stable(writePermit_r))
    else $error("register changed during write");

  done_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timerDone |=> doneFlag_r && !busy)
    else $error("completion did not set flag and clear busy");

  flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    doneFlag_r && !doneClear |=> doneFlag_r)
    else $error("done flag dropped without clear");

  pwrt_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pwrtDone_r |=> !$rose(busy))
    else $error("write started during power-up timer");

  abort_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    abortEvt |=> abortFlag_r && !busy)
    else $error("abort not flagged");

  cp_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    codeProtect && (extReq.rd || extReq.wr) |=> extRsp_r.denied && extRsp_r.rdata == nv_access_pkg::BYTE_ZERO)
    else $error("external access passed code protect");

  key_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    read && !busAck_r && hit(address, nv_access_pkg::OFS_KEY) |=> readdata_r == '0 && !waitrequest)
    else $error("unlock key read not zero");

  upper_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    read && !busAck_r && hit(address, nv_access_pkg::OFS_ADDR_UPPER) |=> readdata_r[7:UB] == '0)
    else $error("upper address unused bits not zero");

  // Array checks look through memRd; the address is locked while busy
  same_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && writedata[nv_access_pkg::CTRL_WR] && writedata[nv_access_pkg::CTRL_PERMIT] && !writePermit_r |=> !busy)
    else $error("write started by the write that set permit");

  erase_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    startWr |=> memRd == nv_access_pkg::ERASED_BYTE)
    else $error("target not erased at write start");

  program_end_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    timerDone |=> memRd == $past(dataBuf_r))
    else $error("target not programmed at write end");

  ext_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && (extReq.rd || extReq.wr) |=> extRsp_r.denied)
    else $error("external access passed during write");

  sel_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && writedata[nv_access_pkg::CTRL_RD] && !softRst
    && (writedata[nv_access_pkg::CTRL_PGM] || writedata[nv_access_pkg::CTRL_CFG]) |=> $stable(dataBuf_r))
    else $error("read strobe with select bit loaded buffer");

  key_consume_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    startWr |=> !keyArmed)
    else $error("unlock sequence reused after start");

  status_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    doneClear && !timerDone |=> !doneFlag_r)
    else $error("done flag not cleared by software");

  ctrl_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && write && busAck_r && hit(address, nv_access_pkg::OFS_CTRL) |=> $stable(pgmSel_r) && $stable(cfgSel_r))
    else $error("control changed during write");

  read_cov: cover property (@(posedge core_clk) disable iff (!rst_n) rdGo);
  write_cov: cover property (@(posedge core_clk) disable iff (!rst_n) timerDone);
  abort_cov: cover property (@(posedge core_clk) disable iff (!rst_n) abortEvt);
  refuse_cov: cover property (@(posedge core_clk) disable iff (!rst_n) wrCtrl && writedata[nv_access_pkg::CTRL_WR] && !startWr);
  denied_cov: cover property (@(posedge core_clk) disable iff (!rst_n) extRsp_r.denied);
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the data nonvolatile byte access block
// Assumes: short power-up and write timers, one Avalon master with one request at a time
// Notes: bus answers and the busy-cycle count taken at the rising edge, other outputs on the falling edge; inputs driven at the rising edge
`timescale 1ns/10ps
module tb;
  localparam int PW = 20;
  localparam int WC = 8;
  typedef struct packed {
    logic [4:0] ofs;
    logic [7:0] wv;
    logic [7:0] exp;
  } row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic masterClearReset = 1'b0;
  logic watchdogReset = 1'b0;
  logic codeProtect = 1'b0;
  nv_access_pkg::ext_req_t extReq = '0;
  nv_access_pkg::ext_rsp_t extRsp;
  logic writeDoneFlag;
  logic writeBusy;
  int badCount = 0;
  int cmpCount = 0;
  int busyCycles = 0;
  // Upper address keeps two bits; unlock key and unmapped space read zero
  row_t rows [6] = '{'{nv_access_pkg::OFS_ADDR_LOWER, 8'h5A, 8'h5A}, '{nv_access_pkg::OFS_ADDR_UPPER, 8'hFF, 8'h03},
    '{nv_access_pkg::OFS_DATA, 8'hC3, 8'hC3}, '{nv_access_pkg::OFS_KEY, 8'h55, 8'h00},
    '{5'h18, 8'h77, 8'h00}, '{nv_access_pkg::OFS_ADDR_UPPER, 8'h02, 8'h02}};

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (writeBusy === 1'b1) begin
      busyCycles <= busyCycles + 1;
    end
  end

  nv_access_ctrl #(.PWRT_CYCLES(PW), .WRITE_CYCLES(WC)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .masterClearReset(masterClearReset), .watchdogReset(watchdogReset), .codeProtect(codeProtect),
    .extReq(extReq), .extRsp(extRsp), .writeDoneFlag(writeDoneFlag), .writeBusy(writeBusy)
  );

  task automatic printVerdict();
    $display("Counts: %0d compares, %0d mismatches", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic note(input string s);
    $display("Test done: %s (%0d mismatches so far)", s, badCount);
  endtask

  // Request held until waitrequest is sampled low at a rising edge; data taken and request released there
  task automatic bus(input logic isWr, input logic [4:0] ofs, input logic [7:0] wd, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(posedge core_clk);
    address <= ofs;
    write <= isWr;
    read <= ~isWr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge core_clk);
      n++;
      q = readdata[7:0];
    end while (waitrequest !== 1'b0 && n < 50);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      badCount++;
      $display("ERROR t=%0t bus request never answered", $time);
      printVerdict();
    end
  endtask

  task automatic wr8(input logic [4:0] ofs, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, ofs, wd, q);
  endtask

  task automatic rdChk(input logic [4:0] ofs, input logic [7:0] exp, input string what);
    logic [7:0] q;
    bus(1'b0, ofs, 8'h00, q);
    chk(q, exp, what);
  endtask

  // Two key writes then a control write; busy sampled after that edge settles
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl, input logic expBusy);
    wr8(nv_access_pkg::OFS_KEY, k1);
    wr8(nv_access_pkg::OFS_KEY, k2);
    wr8(nv_access_pkg::OFS_CTRL, ctl);
    @(negedge core_clk);
    chk({7'h00, writeBusy}, {7'h00, expBusy}, "busy after start attempt");
  endtask

  task automatic waitIdle();
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) begin
      badCount++;
      $display("ERROR t=%0t write never finished", $time);
      printVerdict();
    end
  endtask

  task automatic ext(input logic isWr, input logic [9:0] a, input logic [7:0] d, input logic den,
                     input logic [7:0] exp);
    @(posedge core_clk);
    extReq <= '{rd: ~isWr, wr: isWr, addr: a, wdata: d};
    @(posedge core_clk);
    extReq <= '0;
    @(negedge core_clk);
    chk({extRsp.ack, extRsp.denied, 6'h00}, {1'b1, den, 6'h00}, "external answer");
    chk(extRsp.rdata, exp, "external data");
  endtask

  task automatic softRst(input logic viaWatchdog);
    @(posedge core_clk);
    if (viaWatchdog) begin
      watchdogReset <= 1'b1;
    end else begin
      masterClearReset <= 1'b1;
    end
    @(posedge core_clk);
    watchdogReset <= 1'b0;
    masterClearReset <= 1'b0;
    @(negedge core_clk);
  endtask

  initial begin
    #100000;
    badCount++;
    $display("ERROR t=%0t run timed out", $time);
    printVerdict();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr8(rows[i].ofs, rows[i].wv);
      rdChk(rows[i].ofs, rows[i].exp, "register row");
    end
    note("register rows");
    // Second power-on: start attempt must fall inside the power-up window
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(nv_access_pkg::OFS_CTRL, 8'h00, "control after power-on");
    wr8(nv_access_pkg::OFS_CTRL, 8'h04);
    unlock(8'h55, 8'hAA, 8'h06, 1'b0);
    rdChk(nv_access_pkg::OFS_DATA, 8'h00, "data after power-on");
    note("power-up lockout");
    repeat (PW) @(posedge core_clk);
    codeProtect <= 1'b1;
    wr8(nv_access_pkg::OFS_ADDR_LOWER, 8'hFF);
    wr8(nv_access_pkg::OFS_ADDR_UPPER, 8'h03);
    wr8(nv_access_pkg::OFS_DATA, 8'hA5);
    unlock(8'h55, 8'hAA, 8'h06, 1'b1);
    wr8(nv_access_pkg::OFS_DATA, 8'h11);
    wr8(nv_access_pkg::OFS_CTRL, 8'h00);
    waitIdle();
    chk({7'h00, writeDoneFlag}, 8'h01, "done flag at write end");
    chk(8'(busyCycles), 8'(WC), "busy cycles of one write");
    rdChk(nv_access_pkg::OFS_CTRL, 8'h04, "control after write");
    rdChk(nv_access_pkg::OFS_DATA, 8'hA5, "data kept during write");
    wr8(nv_access_pkg::OFS_DATA, 8'h00);
    wr8(nv_access_pkg::OFS_CTRL, 8'h05);
    rdChk(nv_access_pkg::OFS_DATA, 8'hA5, "read back written byte");
    ext(1'b0, 10'h3FF, 8'h00, 1'b1, 8'h00);
    ext(1'b1, 10'h3FF, 8'h00, 1'b1, 8'h00);
    @(posedge core_clk);
    codeProtect <= 1'b0;
    ext(1'b0, 10'h3FF, 8'h00, 1'b0, 8'hA5);
    ext(1'b1, 10'h001, 8'h5A, 1'b0, 8'h00);
    ext(1'b0, 10'h001, 8'h00, 1'b0, 8'h5A);
    chk({7'h00, writeDoneFlag}, 8'h01, "done flag sticky");
    wr8(nv_access_pkg::OFS_STATUS, 8'h01);
    @(negedge core_clk);
    chk({7'h00, writeDoneFlag}, 8'h00, "done flag cleared");
    note("byte write and read");
    // Refused starts: wrong key order, interleaved write, select bit set, no permit, permit in same write
    unlock(8'hAA, 8'h55, 8'h06, 1'b0);
    wr8(nv_access_pkg::OFS_KEY, 8'h55);
    wr8(nv_access_pkg::OFS_DATA, 8'h3C);
    wr8(nv_access_pkg::OFS_KEY, 8'hAA);
    wr8(nv_access_pkg::OFS_CTRL, 8'h06);
    @(negedge core_clk);
    chk({7'h00, writeBusy}, 8'h00, "start after interleaved write");
    unlock(8'h55, 8'hAA, 8'h46, 1'b0);
    wr8(nv_access_pkg::OFS_CTRL, 8'h00);
    unlock(8'h55, 8'hAA, 8'h02, 1'b0);
    unlock(8'h55, 8'hAA, 8'h06, 1'b0);
    rdChk(nv_access_pkg::OFS_CTRL, 8'h04, "permit stored alone");
    note("refused starts");
    // Read strobe with program select set must leave the buffer alone
    wr8(nv_access_pkg::OFS_DATA, 8'h77);
    wr8(nv_access_pkg::OFS_CTRL, 8'h85);
    rdChk(nv_access_pkg::OFS_DATA, 8'h77, "strobe with select set");
    wr8(nv_access_pkg::OFS_CTRL, 8'h04);
    note("read strobe select");
    for (int k = 0; k < 2; k++) begin
      unlock(8'h55, 8'hAA, 8'h06, 1'b1);
      ext(1'b0, 10'h001, 8'h00, 1'b1, 8'h00);
      softRst(k[0]);
      chk({7'h00, writeBusy}, 8'h00, "busy after soft reset");
      rdChk(nv_access_pkg::OFS_CTRL, 8'h08, "abort flag set");
      rdChk(nv_access_pkg::OFS_ADDR_LOWER, 8'h00, "address zeroed");
      wr8(nv_access_pkg::OFS_CTRL, 8'h04);
    end
    note("aborted writes");
    printVerdict();
  end
endmodule
